// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   reg pwrite = 1'b0, src_start = 1'b0, src_error = 1'b0, src_valid = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000, rd;
   reg [7:0] src_data = 8'h00;
   reg [8:0] cfg_m = 9'h1E0;
   reg e_m = 1'b0, full_seen = 1'b0, er;
   wire [31:0] prdata;
   wire [7:0] stream_data_bus, rx_byte;
   wire pready, pslverr, src_ready, stream_clock_out, packet_start_flag;
   wire packet_error_flag, packet_valid_flag, rx_stb, rx_start;
   wire rx_err, rx_valid;
   integer n_mismatch = 0, n_checks = 0, cyc = 0;
   integer pos, nv, nrx, flen, i, k;

   tsof_formatter dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_data(src_data),
      .src_start(src_start), .src_error(src_error), .src_valid(src_valid),
      .src_ready(src_ready), .stream_clock_out(stream_clock_out),
      .stream_data_bus(stream_data_bus),
      .packet_start_flag(packet_start_flag),
      .packet_error_flag(packet_error_flag),
      .packet_valid_flag(packet_valid_flag)
   );
   tsof_rx_model u_rx (
      .pclk(pclk), .presetn(presetn), .ser(cfg_m[1]), .pol(cfg_m[8:5]),
      .sclk(stream_clock_out), .sdata(stream_data_bus),
      .sstart(packet_start_flag), .serr(packet_error_flag),
      .svalid(packet_valid_flag), .rx_stb(rx_stb), .rx_byte(rx_byte),
      .rx_start(rx_start), .rx_err(rx_err), .rx_valid(rx_valid)
   );

   always #50 pclk = ~pclk;

   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
         end
      end
   endtask

   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rst;
      begin
         presetn <= 1'b0;
         repeat (8) @(posedge pclk);
         presetn <= 1'b1;
      end
   endtask

   // Source outruns the output, so the FIFO fills and refuses
   task send(input integer n);
      begin
         for (i = 0; i < n; i = i + 1) begin
            src_data <= i[7:0];
            src_start <= i % 188 == 0;
            src_error <= e_m;
            src_valid <= 1'b1;
            @(posedge pclk);
            while (src_ready !== 1'b1) begin
               full_seen = 1'b1;
               @(posedge pclk);
            end
         end
         src_valid <= 1'b0;
      end
   endtask

   task run(input [8:0] cfg, input e, input integer npk);
      begin
         rst;
         cfg_m = cfg;
         e_m = e;
         flen = 188 + (cfg[2] ? (cfg[4:3] == 2'h0 ? 20 : 16) : 0);
         pos = 0;
         nv = 0;
         nrx = 0;
         apb(1'b1, 12'h000, {23'h0, cfg});
         apb(1'b1, 12'h000, {23'h0, cfg | 9'h001});
         apb(1'b0, 12'h000, 32'h0);
         chk("control", {23'h0, cfg | 9'h001}, rd);
         send(npk * 188);
         while (nrx < flen * npk)
            @(posedge pclk);
         repeat (80) @(posedge pclk);
         chk("units", flen * npk, nrx);
         apb(1'b0, 12'h004, 32'h0);
         chk("packets", npk, {20'h0, rd[31:20]});
         $display("test done, control %h", cfg);
      end
   endtask

   always @(posedge pclk) begin
      if (rx_stb === 1'b1) begin
         if (pos < 188) begin
            chk("data", nv[7:0], rx_byte);
            chk("start", pos == 0, rx_start);
            chk("valid", 1, rx_valid);
            chk("error", e_m, rx_err);
            nv = nv + 1;
         end else begin
            chk("fill", 0, {rx_byte, rx_valid, rx_err});
         end
         pos = pos + 1 == flen ? 0 : pos + 1;
         nrx = nrx + 1;
      end
   end

   task close_out;
      begin
         $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end

   initial begin
      rst;
      apb(1'b0, 12'h000, 32'h0);
      chk("control reset", 32'h000001E0, rd);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h004, 32'h0);
      chk("status idle", 32'h00000800, rd);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      $display("test done, registers");
      run(9'h1E0, 1'b0, 2);
      chk("fifo full", 1, full_seen);
      for (k = 0; k < 3; k = k + 1)
         run(9'h1E4 | {4'h0, k[1:0], 3'h0}, k == 1, 1);
      run(9'h012, 1'b1, 1);
      run(9'h0A6, 1'b0, 1);
      run(9'h1F6, 1'b0, 1);
      close_out;
   end
endmodule

// file: verif/tsof_asserts.sv
`timescale 1ns/1ps
module tsof_asserts (
   input wire pclk, // Clock
   input wire presetn, // Reset
   input wire [11:0] paddr, // Address
   input wire psel, // Select
   input wire penable, // Enable
   input wire pwrite, // Write
   input wire [31:0] pwdata, // Write data
   input wire pready, // Ready
   input wire stream_clock_out, // Clock out
   input wire [7:0] stream_data_bus, // Data out
   input wire packet_start_flag, // Start
   input wire packet_error_flag, // Error
   input wire packet_valid_flag // Valid
);
   reg [8:0] ctrl;
   reg [3:0] icnt;
   reg armed, seen;
   wire en = ctrl[0];
   wire ser = ctrl[1];
   wire red = ctrl[2];
   wire act = stream_clock_out == ctrl[5];
   wire st = packet_start_flag == ctrl[6];
   wire er = packet_error_flag == ctrl[7];
   wire vl = packet_valid_flag == ctrl[8];
   wire [3:0] hval = ser ? 4'h1 : ctrl[4:3] == 2'h1 ? 4'h2 :
      ctrl[4:3] == 2'h2 ? (red ? 4'h1 : 4'h2) : (red ? 4'h2 : 4'h3);
   // Shadow of the control word, so polarities are known from the ports
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 9'h1E0;
         icnt <= 4'h0;
         armed <= 1'b0;
         seen <= 1'b0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == 12'h000)
            ctrl <= pwdata[8:0];
         seen <= en && (seen || st);
         armed <= en && (armed || act);
         if (!en || act)
            icnt <= 4'h0;
         else if (icnt != 4'hF)
            icnt <= icnt + 4'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ser_zero;
      ser |-> stream_data_bus[6:0] == 7'h00;
   endproperty
   a_ser_zero: assert property (p_ser_zero) else $error("low lines");
   property p_data_edge;
      en && $changed(stream_data_bus) |-> !act;
   endproperty
   a_data_edge: assert property (p_data_edge) else $error("data edge");
   // Active phase may stretch on an empty FIFO, so only the idle phase counts
   property p_inact_len;
      en && armed && act && !$past(act) |-> icnt == hval;
   endproperty
   a_inact_len: assert property (p_inact_len) else $error("rate");
   property p_start_held;
      en && ser && st && !$past(st) |-> st [*8];
   endproperty
   a_start_held: assert property (p_start_held) else $error("start");
   property p_dataonly_valid;
      en && !red && seen |-> vl;
   endproperty
   a_dataonly_valid: assert property (p_dataonly_valid) else $error("v");
   property p_red_fill;
      en && red && seen && !vl |-> stream_data_bus == 8'h00 && !er;
   endproperty
   a_red_fill: assert property (p_red_fill) else $error("fill");
   property p_start_valid;
      en && st |-> vl;
   endproperty
   a_start_valid: assert property (p_start_valid) else $error("sv");
   property p_apb_ans;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("ready");
   c_ser: cover property (en && ser && st);
   c_red: cover property (en && red && seen && !vl);
   c_rise: cover property (en && armed && act && !$past(act));
endmodule

bind tsof_formatter tsof_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .stream_clock_out(stream_clock_out), .stream_data_bus(stream_data_bus),
   .packet_start_flag(packet_start_flag),
   .packet_error_flag(packet_error_flag),
   .packet_valid_flag(packet_valid_flag)
);

// file: verif/tsof_rx_model.sv
`timescale 1ns/1ps
module tsof_rx_model (
   input wire pclk, // Clock
   input wire presetn, // Reset
   input wire ser, // Serial
   input wire [3:0] pol, // Polarities
   input wire sclk, // Stream clock
   input wire [7:0] sdata, // Data
   input wire sstart, // Start
   input wire serr, // Error
   input wire svalid, // Valid
   output reg rx_stb, // Byte done
   output reg [7:0] rx_byte, // Byte
   output reg rx_start, // Start on all bits
   output reg rx_err, // Error active
   output reg rx_valid // Valid active
);
   reg prev;
   reg [2:0] bcnt;
   reg [6:0] sh;
   reg sall;
   wire act = sclk == pol[0];
   wire st = sstart == pol[1];
   wire nxt = (bcnt == 3'h0 || sall) && st;
   // Starts as if active, so no false edge before the first idle level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b1;
         bcnt <= 3'h0;
         rx_stb <= 1'b0;
      end else begin
         prev <= act;
         rx_stb <= 1'b0;
         if (act && !prev) begin
            sh <= {sh[5:0], sdata[7]};
            sall <= nxt;
            bcnt <= ser ? bcnt + 3'h1 : 3'h0;
            if (!ser || bcnt == 3'h7) begin
               rx_stb <= 1'b1;
               rx_byte <= ser ? {sh, sdata[7]} : sdata;
               rx_start <= ser ? nxt : st;
               rx_err <= serr == pol[2];
               rx_valid <= svalid == pol[3];
            end
         end
      end
   end
endmodule

// file: verilog/tsof_defs.vh
`ifndef TSOF_DEFS_VH
`define TSOF_DEFS_VH

// APB register byte offsets
`define TSOF_CTRL_OFS 12'h000
`define TSOF_STAT_OFS 12'h004

// Control register fields
`define TSOF_CTRL_EN 0
`define TSOF_CTRL_SER 1
`define TSOF_CTRL_RED 2
`define TSOF_CTRL_DEM_LO 3
`define TSOF_CTRL_DEM_HI 4
`define TSOF_CTRL_PCLK 5
`define TSOF_CTRL_PSTART 6
`define TSOF_CTRL_PERR 7
`define TSOF_CTRL_PVALID 8
`define TSOF_CTRL_W 9
// Disabled, parallel, data only, 8VSB, all flags active high
`define TSOF_CTRL_RST 9'h1E0

// Demodulation mode codes
`define TSOF_DEM_VSB 2'h0
`define TSOF_DEM_Q64 2'h1
`define TSOF_DEM_Q256 2'h2

// Packet layout
`define TSOF_PKT_LEN 188
`define TSOF_RED_VSB 20
`define TSOF_RED_QAM 16

// Clocks in Hz
`define TSOF_PCLK_HZ 10000000
`define TSOF_MAX_BPS 42100000
// Data only, serial clock (bit rate)
`define TSOF_VSB_DS_HZ 19392660
`define TSOF_Q64_DS_HZ 26970350
`define TSOF_Q256_DS_HZ 38810700
// Data only, parallel clock
`define TSOF_VSB_DP_HZ 2424080
`define TSOF_Q64_DP_HZ 3371290
`define TSOF_Q256_DP_HZ 4851330
// Data plus redundancy, serial clock
`define TSOF_VSB_RS_HZ 21455710
`define TSOF_Q64_RS_HZ 29265700
`define TSOF_Q256_RS_HZ 42113740
// Data plus redundancy, parallel clock
`define TSOF_VSB_RP_HZ 2681960
`define TSOF_Q64_RP_HZ 3658210
`define TSOF_Q256_RP_HZ 5264220

`endif

// file: verilog/tsof_fifo.v
`timescale 1ns/1ps
module tsof_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk, // Clock
   input wire rst_n, // Async reset, active low
   input wire [WIDTH-1:0] in_data, // Write data
   input wire in_valid, // Write request
   output wire in_ready, // Space available
   output wire [WIDTH-1:0] out_data, // Head entry
   output wire out_valid, // Head entry present
   input wire out_ready, // Consumer takes head
   output wire [AW:0] level // Entries held
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   reg room;
   wire push;
   wire pop;

   // Room is kept as its own flop so the ready output needs no gate
   assign push = in_valid & room;
   assign pop = out_valid & out_ready;
   assign in_ready = room;
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign level = count;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         room <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} :
                      wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} :
                      rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
            room <= (count != DEPTH - 1);
         end else if (pop & ~push) begin
            count <= count - 1'b1;
            room <= 1'b1;
         end
      end
   end
endmodule

// file: verilog/tsof_formatter.v
// How it works
// - Parallel: byte on bus, all 8 bits at once
// - Serial: line 7 only, MSB first
// - Serial bit rate never above 42.1 Mbit/s
// - Four flag polarities individually programmable
// - Stream clock times parallel and serial data
// - Start flag only on first packet byte
// - Valid flag marks periods with packet data
// - Data only: 188-byte packets back to back
// - Data only: valid flag always active
// - Redundancy mode: valid only on data bytes
// - Redundancy bytes: 20 VSB, 16 QAM
// - VSB clock rates per output mode
// - 64QAM clock rates per output mode
// - 256QAM clock rates per output mode
`timescale 1ns/1ps
`include "tsof_defs.vh"
module tsof_formatter #(
   parameter CLK_HZ = `TSOF_PCLK_HZ,
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   input wire pclk, // APB and block clock
   input wire presetn, // Async reset, active low
   input wire [11:0] paddr, // APB address
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB write
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error, unmapped address
   input wire [7:0] src_data, // Decoded stream byte
   input wire src_start, // Byte is first of a packet
   input wire src_error, // Byte belongs to bad packet
   input wire src_valid, // Source byte offered
   output wire src_ready, // FIFO has room
   output reg stream_clock_out, // Output stream clock
   output reg [7:0] stream_data_bus, // Output data
   output reg packet_start_flag, // Packet start flag
   output reg packet_error_flag, // Packet error flag
   output reg packet_valid_flag // Packet valid flag
);
   localparam S_IDLE = 3'b001;
   localparam S_DATA = 3'b010;
   localparam S_RED = 3'b100;

   // Half period of the stream clock in pclk cycles. Rounding up keeps
   // every mode at or below its listed rate; at a slow pclk the output
   // of every mode listed above pclk/2 runs at pclk/2.
   function [7:0] half_of;
      input integer rate;
      integer h;
      begin
         h = (CLK_HZ + 2 * rate - 1) / (2 * rate);
         if (h < 1) h = 1;
         if (h > 255) h = 255;
         half_of = h[7:0];
      end
   endfunction

   localparam [7:0] H_VSB_DS = half_of(`TSOF_VSB_DS_HZ);
   localparam [7:0] H_VSB_DP = half_of(`TSOF_VSB_DP_HZ);
   localparam [7:0] H_VSB_RS = half_of(`TSOF_VSB_RS_HZ);
   localparam [7:0] H_VSB_RP = half_of(`TSOF_VSB_RP_HZ);
   localparam [7:0] H_Q64_DS = half_of(`TSOF_Q64_DS_HZ);
   localparam [7:0] H_Q64_DP = half_of(`TSOF_Q64_DP_HZ);
   localparam [7:0] H_Q64_RS = half_of(`TSOF_Q64_RS_HZ);
   localparam [7:0] H_Q64_RP = half_of(`TSOF_Q64_RP_HZ);
   localparam [7:0] H_Q256_DS = half_of(`TSOF_Q256_DS_HZ);
   localparam [7:0] H_Q256_DP = half_of(`TSOF_Q256_DP_HZ);
   localparam [7:0] H_Q256_RS = half_of(`TSOF_Q256_RS_HZ);
   localparam [7:0] H_Q256_RP = half_of(`TSOF_Q256_RP_HZ);
   // Floor for any serial mode, no faster than the ceiling bit rate
   localparam [7:0] H_MIN = half_of(`TSOF_MAX_BPS);

   localparam [7:0] LAST_DATA = `TSOF_PKT_LEN - 1;
   localparam [7:0] LAST_RVSB = `TSOF_RED_VSB - 1;
   localparam [7:0] LAST_RQAM = `TSOF_RED_QAM - 1;

   // Registers
   reg [`TSOF_CTRL_W-1:0] ctrl;
   reg [11:0] pkt_count;

   wire enable = ctrl[`TSOF_CTRL_EN];
   wire serial = ctrl[`TSOF_CTRL_SER];
   wire redund = ctrl[`TSOF_CTRL_RED];
   wire [1:0] demod = ctrl[`TSOF_CTRL_DEM_HI:`TSOF_CTRL_DEM_LO];
   wire pol_clk = ctrl[`TSOF_CTRL_PCLK];
   wire pol_start = ctrl[`TSOF_CTRL_PSTART];
   wire pol_err = ctrl[`TSOF_CTRL_PERR];
   wire pol_valid = ctrl[`TSOF_CTRL_PVALID];

   // FIFO between source and formatter
   wire [9:0] f_data;
   wire f_valid;
   reg f_pop;
   wire [FIFO_AW:0] f_level;

   tsof_fifo #(
      .WIDTH(10),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_data({src_start, src_error, src_data}),
      .in_valid(src_valid),
      .in_ready(src_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .level(f_level)
   );

   // Formatter state
   reg [2:0] state;
   reg [7:0] half_cnt;
   reg lvl;
   reg [7:0] byte_cnt;
   reg [2:0] bit_cnt;
   reg [7:0] shreg;
   reg cur_err;
   reg cur_valid;
   reg cur_start;

   reg [2:0] next_state;
   reg [7:0] next_half_cnt;
   reg next_lvl;
   reg [7:0] next_byte_cnt;
   reg [2:0] next_bit_cnt;
   reg [7:0] next_shreg;
   reg next_err;
   reg next_valid;
   reg next_start;
   reg next_pkt;

   reg [7:0] half_sel;
   reg [7:0] half_raw;
   wire [7:0] last_red;
   wire tick;
   wire byte_done;
   wire last_data;
   wire last_redund;
   wire running;

   // Rate table by demod mode, data or redundancy, serial or parallel
   always @* begin
      case ({demod, redund, serial})
         {`TSOF_DEM_VSB, 2'b00}: half_raw = H_VSB_DP;
         {`TSOF_DEM_VSB, 2'b01}: half_raw = H_VSB_DS;
         {`TSOF_DEM_VSB, 2'b10}: half_raw = H_VSB_RP;
         {`TSOF_DEM_VSB, 2'b11}: half_raw = H_VSB_RS;
         {`TSOF_DEM_Q64, 2'b00}: half_raw = H_Q64_DP;
         {`TSOF_DEM_Q64, 2'b01}: half_raw = H_Q64_DS;
         {`TSOF_DEM_Q64, 2'b10}: half_raw = H_Q64_RP;
         {`TSOF_DEM_Q64, 2'b11}: half_raw = H_Q64_RS;
         {`TSOF_DEM_Q256, 2'b00}: half_raw = H_Q256_DP;
         {`TSOF_DEM_Q256, 2'b01}: half_raw = H_Q256_DS;
         {`TSOF_DEM_Q256, 2'b10}: half_raw = H_Q256_RP;
         {`TSOF_DEM_Q256, 2'b11}: half_raw = H_Q256_RS;
         default: half_raw = H_VSB_DP;
      endcase
      half_sel = (half_raw < H_MIN) ? H_MIN : half_raw;
   end

   assign last_red = (demod == `TSOF_DEM_VSB) ? LAST_RVSB : LAST_RQAM;
   assign tick = (half_cnt == 8'h00);
   assign byte_done = ~serial | (bit_cnt == 3'h7);
   assign last_data = (state == S_DATA) & (byte_cnt == LAST_DATA);
   assign last_redund = (state == S_RED) & (byte_cnt == last_red);
   assign running = (state != S_IDLE);

   // Each unit (bit or byte) is one clock period: low half, then high
   // half; the unit advances only when its high half ends.
   always @* begin
      next_state = state;
      next_half_cnt = half_cnt;
      next_lvl = lvl;
      next_byte_cnt = byte_cnt;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_err = cur_err;
      next_valid = cur_valid;
      next_start = cur_start;
      next_pkt = 1'b0;
      f_pop = 1'b0;
      case (state)
         S_IDLE: begin
            next_lvl = 1'b0;
            next_shreg = 8'h00;
            // Drop bytes until a packet start reaches the head
            if (enable & f_valid) begin
               f_pop = 1'b1;
               if (f_data[9]) begin
                  next_state = S_DATA;
                  next_byte_cnt = 8'h00;
                  next_bit_cnt = 3'h0;
                  next_shreg = f_data[7:0];
                  next_err = f_data[8];
                  next_valid = 1'b1;
                  next_start = 1'b1;
                  next_half_cnt = half_sel - 8'h01;
                  next_pkt = 1'b1;
               end
            end
         end
         S_DATA, S_RED: begin
            if (!enable) begin
               next_state = S_IDLE;
               next_lvl = 1'b0;
               next_valid = 1'b0;
               next_start = 1'b0;
               next_err = 1'b0;
            end else if (!tick) begin
               next_half_cnt = half_cnt - 8'h01;
            end else if (!lvl) begin
               next_lvl = 1'b1;
               next_half_cnt = half_sel - 8'h01;
            end else if (!byte_done) begin
               // Next bit; start flag holds for the whole byte
               next_bit_cnt = bit_cnt + 3'h1;
               next_shreg = {shreg[6:0], 1'b0};
               next_lvl = 1'b0;
               next_half_cnt = half_sel - 8'h01;
            end else if (last_data & redund) begin
               next_state = S_RED;
               next_byte_cnt = 8'h00;
               next_bit_cnt = 3'h0;
               next_shreg = 8'h00;
               next_err = 1'b0;
               next_valid = 1'b0;
               next_start = 1'b0;
               next_lvl = 1'b0;
               next_half_cnt = half_sel - 8'h01;
            end else if ((state == S_RED) & ~last_redund) begin
               next_byte_cnt = byte_cnt + 8'h01;
               next_bit_cnt = 3'h0;
               next_lvl = 1'b0;
               next_half_cnt = half_sel - 8'h01;
            end else if (f_valid) begin
               // Next data byte, or first of the next packet with no gap
               f_pop = 1'b1;
               next_state = S_DATA;
               if (last_data | last_redund) begin
                  next_byte_cnt = 8'h00;
                  next_start = 1'b1;
                  next_pkt = 1'b1;
               end else begin
                  next_byte_cnt = byte_cnt + 8'h01;
                  next_start = 1'b0;
               end
               next_bit_cnt = 3'h0;
               next_shreg = f_data[7:0];
               next_err = f_data[8];
               next_valid = 1'b1;
               next_lvl = 1'b0;
               next_half_cnt = half_sel - 8'h01;
            end
            // FIFO empty: clock holds high until a byte arrives
         end
         default: begin
            next_state = S_IDLE;
            next_lvl = 1'b0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         half_cnt <= 8'h00;
         lvl <= 1'b0;
         byte_cnt <= 8'h00;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         cur_err <= 1'b0;
         cur_valid <= 1'b0;
         cur_start <= 1'b0;
         pkt_count <= 12'h000;
      end else begin
         state <= next_state;
         half_cnt <= next_half_cnt;
         lvl <= next_lvl;
         byte_cnt <= next_byte_cnt;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         cur_err <= next_err;
         cur_valid <= next_valid;
         cur_start <= next_start;
         if (next_pkt) begin
            pkt_count <= pkt_count + 12'h001;
         end
      end
   end

   // Pin stage. Data change while the clock goes inactive, so the
   // receiver's active edge lands mid-period.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stream_clock_out <= 1'b0;
         stream_data_bus <= 8'h00;
         packet_start_flag <= 1'b0;
         packet_error_flag <= 1'b0;
         packet_valid_flag <= 1'b0;
      end else begin
         stream_clock_out <= lvl ^ ~pol_clk;
         if (serial) begin
            stream_data_bus <= {shreg[7], 7'h00};
         end else begin
            stream_data_bus <= shreg;
         end
         packet_start_flag <= (running & cur_start) ^ ~pol_start;
         packet_error_flag <= (running & cur_err) ^ ~pol_err;
         if (redund) begin
            packet_valid_flag <= (running & cur_valid) ^ ~pol_valid;
         end else begin
            packet_valid_flag <= running ^ ~pol_valid;
         end
      end
   end

   // APB slave: one wait state, write lands with pready high
   wire ctrl_hit = (paddr == `TSOF_CTRL_OFS);
   wire stat_hit = (paddr == `TSOF_STAT_OFS);
   wire access = psel & penable;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `TSOF_CTRL_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access & ~pready;
         if (access & ~pready) begin
            pslverr <= ~(ctrl_hit | stat_hit);
            if (!pwrite & ctrl_hit) begin
               prdata <= {{(32-`TSOF_CTRL_W){1'b0}}, ctrl};
            end else if (!pwrite & stat_hit) begin
               prdata <= {pkt_count, {(5-FIFO_AW){1'b0}}, f_level,
                          state, bit_cnt, byte_cnt};
            end else begin
               prdata <= 32'h00000000;
            end
         end else begin
            // Error stands with pready only, not into the next cycle
            pslverr <= 1'b0;
         end
         if (access & pready & pwrite & ctrl_hit) begin
            ctrl <= pwdata[`TSOF_CTRL_W-1:0];
         end
      end
   end
endmodule
